// ==== shared/aso_pkg.sv ====
// Notes on behaviour
// - each of the eight converters gets its own serial lane, twelve bits per input clock
// - word-frame lane toggles each word, at half the input clock rate
// - bit clock runs at six times input clock, both edges carry a bit
// - standby powers everything down except the reference generator, fast recovery
// - full power-down keeps only digital logic alive, slower recovery than standby
// - eight-bit mask, one bit per converter, powers down that converter's channel pair
// - one control bit powers down the serial output drivers alone
// - converter samples even channel then odd channel; lane alternates between them
package aso_pkg;

    // apb register map, byte addresses
    localparam logic [7:0] ADDR_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_PAIR_PD  = 8'h04;
    localparam logic [7:0] ADDR_STATUS   = 8'h08;

    // control register fields
    localparam int CTRL_STANDBY_BIT   = 0;
    localparam int CTRL_FULL_PD_BIT   = 1;
    localparam int CTRL_SER_PD_BIT    = 2;
    localparam logic [2:0] CTRL_RESET = 3'h0;
    localparam logic [7:0] PAIR_RESET = 8'h00;

    // status register fields
    localparam int STAT_READY_BIT   = 0;
    localparam int STAT_REF_BIT     = 1;
    localparam int STAT_CORE_BIT    = 2;
    localparam int STAT_LINK_BIT    = 3;

    // stream shape
    localparam int NUM_CONV   = 8;
    localparam int WORD_BITS  = 12;
    localparam logic [3:0] LAST_BIT = 4'hB;

    // wake-up times after leaving a power-down state
    localparam int CLK_PERIOD_NS   = 20;
    localparam int WAKE_STANDBY_NS = 1000;
    localparam int WAKE_FULL_NS    = 100000;
    localparam int WAKE_STANDBY_CYC = (WAKE_STANDBY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAKE_FULL_CYC    = (WAKE_FULL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [3:0] {
        PWR_RUN     = 4'h1,
        PWR_STANDBY = 4'h2,
        PWR_OFF     = 4'h4,
        PWR_WAKE    = 4'h8
    } aso_pwr_t;

endpackage : aso_pkg

// ==== core/aso_sync.sv ====
`timescale 1ns/10ps
module aso_sync #(
    parameter int WIDTH = 1
) (
    // destination clock
    input  wire logic             clk,
    input  wire logic             rst_n,
    // levels
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] meta_q;

    // first stage is read only by the second
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            dout   <= '0;
        end else begin
            meta_q <= din;
            dout   <= meta_q;
        end
    end

endmodule : aso_sync

// ==== core/aso_lane.sv ====
`timescale 1ns/10ps
module aso_lane #(
    parameter int WIDTH = 12
) (
    // link clock
    input  wire logic             clk,
    input  wire logic             rst_n,
    // word in
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] word,
    input  wire logic             enable,
    // serial out
    output logic                  ser_q
);

    logic [WIDTH-2:0] shift_q;

    // msb goes out first, in the cycle the frame edge appears
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            shift_q <= '0;
            ser_q   <= 1'b0;
        end else if (load) begin
            shift_q <= word[WIDTH-2:0];
            ser_q   <= enable & word[WIDTH-1];
        end else begin
            shift_q <= {shift_q[WIDTH-3:0], 1'b0};
            ser_q   <= enable & shift_q[WIDTH-2];
        end
    end

endmodule : aso_lane

// ==== core/aso_top.sv ====
// Design decisions made here: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
module aso_top #(
    parameter int NUM_CONV      = aso_pkg::NUM_CONV,
    parameter int WORD_BITS     = aso_pkg::WORD_BITS,
    parameter int WAKE_FULL_CYC = aso_pkg::WAKE_FULL_CYC
) (
    // apb
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [7:0]                    paddr,
    input  wire logic [31:0]                   pwdata,
    output logic      [31:0]                   prdata,
    output logic                               pready,
    output logic                               pslverr,
    // power controls to the analog side
    output logic                               reference_en,
    output logic                               core_en,
    output logic      [NUM_CONV-1:0]           pair_power_en,
    // link side, runs on the serial bit clock
    input  wire logic                          link_clk,
    input  wire logic [NUM_CONV*WORD_BITS-1:0] conv_result,
    output logic                               conv_odd,
    output logic      [NUM_CONV-1:0]           lane_data,
    output logic      [NUM_CONV-1:0]           lane_en,
    output logic                               frame_out,
    output logic                               bitclk_out,
    output logic                               serial_drv_en
);

    localparam int WAKE_STBY = aso_pkg::WAKE_STANDBY_CYC;

    // apb slave state
    logic [2:0]          ctrl_q;
    logic [NUM_CONV-1:0] pair_pd_q;
    logic                ack_q;
    logic                err_q;
    logic [31:0]         rdata_q;
    logic                access;
    logic                wr_fire;
    logic                addr_ok;
    logic [31:0]         rd_mux;

    // power state
    aso_pkg::aso_pwr_t   pwr_q;
    aso_pkg::aso_pwr_t   pwr_d;
    logic [31:0]         wake_cnt_q;
    logic [31:0]         wake_cnt_d;
    logic                want_off;
    logic                want_stby;
    logic                serial_on;

    // crossings
    logic [NUM_CONV:0]   to_link;
    logic [NUM_CONV:0]   at_link;
    logic                link_active_s;

    // link domain
    logic                lrst_meta_q;
    logic                lrst_n_q;
    logic [3:0]          bit_cnt_q;
    logic                load;
    logic                frame_q;
    logic                bitclk_q;
    logic                odd_q;
    logic                drv_q;
    logic                drv_nx;
    logic [NUM_CONV-1:0] lane_en_q;
    logic [NUM_CONV-1:0] lane_en_nx;
    logic                link_active_q;

    // the system's reset pulse after power-up clears every control bit
    assign access  = psel & penable;
    assign wr_fire = access & ack_q & pwrite;
    assign addr_ok = (paddr == aso_pkg::ADDR_CTRL) ||
                     (paddr == aso_pkg::ADDR_PAIR_PD) ||
                     (paddr == aso_pkg::ADDR_STATUS);

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (paddr)
            aso_pkg::ADDR_CTRL: begin
                rd_mux[2:0] = ctrl_q;
            end
            aso_pkg::ADDR_PAIR_PD: begin
                rd_mux[NUM_CONV-1:0] = pair_pd_q;
            end
            aso_pkg::ADDR_STATUS: begin
                rd_mux[aso_pkg::STAT_READY_BIT] = (pwr_q == aso_pkg::PWR_RUN);
                rd_mux[aso_pkg::STAT_REF_BIT]   = reference_en;
                rd_mux[aso_pkg::STAT_CORE_BIT]  = core_en;
                rd_mux[aso_pkg::STAT_LINK_BIT]  = link_active_s;
            end
            default: begin
                rd_mux = 32'h0000_0000;
            end
        endcase
    end

    // one wait state so read data leaves a flip-flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ack_q   <= 1'b0;
            err_q   <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else if (access && !ack_q) begin
            ack_q   <= 1'b1;
            err_q   <= ~addr_ok;
            rdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
        end else begin
            ack_q   <= 1'b0;
            err_q   <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end
    end

    assign pready  = ack_q;
    assign pslverr = err_q;
    assign prdata  = rdata_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= aso_pkg::CTRL_RESET;
        end else if (wr_fire && paddr == aso_pkg::ADDR_CTRL) begin
            ctrl_q <= pwdata[2:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pair_pd_q <= aso_pkg::PAIR_RESET;
        end else if (wr_fire && paddr == aso_pkg::ADDR_PAIR_PD) begin
            pair_pd_q <= pwdata[NUM_CONV-1:0];
        end
    end

    // full power-down outranks standby when both are set
    assign want_off  = ctrl_q[aso_pkg::CTRL_FULL_PD_BIT];
    assign want_stby = ctrl_q[aso_pkg::CTRL_STANDBY_BIT] & ~want_off;

    always_comb begin
        pwr_d      = pwr_q;
        wake_cnt_d = wake_cnt_q;
        case (pwr_q)
            aso_pkg::PWR_RUN: begin
                if (want_off) begin
                    pwr_d = aso_pkg::PWR_OFF;
                end else if (want_stby) begin
                    pwr_d = aso_pkg::PWR_STANDBY;
                end
            end
            aso_pkg::PWR_STANDBY: begin
                if (want_off) begin
                    pwr_d = aso_pkg::PWR_OFF;
                end else if (!want_stby) begin
                    // reference never stopped, so the core settles quickly
                    pwr_d      = aso_pkg::PWR_WAKE;
                    wake_cnt_d = 32'(WAKE_STBY);
                end
            end
            aso_pkg::PWR_OFF: begin
                if (!want_off) begin
                    // reference must restart too, hence the longer wait
                    pwr_d      = want_stby ? aso_pkg::PWR_STANDBY : aso_pkg::PWR_WAKE;
                    wake_cnt_d = 32'(WAKE_FULL_CYC);
                end
            end
            aso_pkg::PWR_WAKE: begin
                if (want_off) begin
                    pwr_d = aso_pkg::PWR_OFF;
                end else if (want_stby) begin
                    pwr_d = aso_pkg::PWR_STANDBY;
                end else if (wake_cnt_q <= 32'h0000_0001) begin
                    pwr_d      = aso_pkg::PWR_RUN;
                    wake_cnt_d = 32'h0000_0000;
                end else begin
                    wake_cnt_d = wake_cnt_q - 32'h0000_0001;
                end
            end
            default: begin
                pwr_d      = aso_pkg::PWR_OFF;
                wake_cnt_d = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwr_q      <= aso_pkg::PWR_RUN;
            wake_cnt_q <= 32'h0000_0000;
        end else begin
            pwr_q      <= pwr_d;
            wake_cnt_q <= wake_cnt_d;
        end
    end

    // power enables are registered from the next state pwr_d, so they change together with the state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reference_en  <= 1'b1;
            core_en       <= 1'b1;
            pair_power_en <= {NUM_CONV{1'b1}};
        end else begin
            reference_en  <= (pwr_d != aso_pkg::PWR_OFF);
            core_en       <= (pwr_d == aso_pkg::PWR_RUN) ||
                             (pwr_d == aso_pkg::PWR_WAKE);
            pair_power_en <= ((pwr_d == aso_pkg::PWR_RUN) ||
                              (pwr_d == aso_pkg::PWR_WAKE)) ?
                             ~pair_pd_q : {NUM_CONV{1'b0}};
        end
    end

    // drivers only run once the core is fully awake
    assign serial_on = (pwr_q == aso_pkg::PWR_RUN) & ~ctrl_q[aso_pkg::CTRL_SER_PD_BIT];
    assign to_link   = {serial_on, pair_power_en};

    aso_sync #(
        .WIDTH (NUM_CONV + 1)
    ) u_sync_to_link (
        .clk   (link_clk),
        .rst_n (lrst_n_q),
        .din   (to_link),
        .dout  (at_link)
    );

    aso_sync #(
        .WIDTH (1)
    ) u_sync_to_apb (
        .clk   (pclk),
        .rst_n (presetn),
        .din   (link_active_q),
        .dout  (link_active_s)
    );

    // link reset asserts at once and releases on the link clock
    always_ff @(posedge link_clk or negedge presetn) begin
        if (!presetn) begin
            lrst_meta_q <= 1'b0;
            lrst_n_q    <= 1'b0;
        end else begin
            lrst_meta_q <= 1'b1;
            lrst_n_q    <= lrst_meta_q;
        end
    end

    // twelve link cycles make one input clock period
    assign load = (bit_cnt_q == aso_pkg::LAST_BIT);

    always_ff @(posedge link_clk or negedge lrst_n_q) begin
        if (!lrst_n_q) begin
            bit_cnt_q <= aso_pkg::LAST_BIT;
        end else if (load) begin
            bit_cnt_q <= 4'h0;
        end else begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
        end
    end

    // frame is high through even words and low through odd ones
    always_ff @(posedge link_clk or negedge lrst_n_q) begin
        if (!lrst_n_q) begin
            frame_q <= 1'b0;
            odd_q   <= 1'b1;
        end else if (load) begin
            frame_q <= odd_q & at_link[NUM_CONV];
            odd_q   <= ~odd_q;
        end
    end

    // enables only take a new value at a load edge, so the bit clock and lanes never tear a word
    assign drv_nx     = load ? at_link[NUM_CONV] : drv_q;
    assign lane_en_nx = load ? at_link[NUM_CONV-1:0] & {NUM_CONV{at_link[NUM_CONV]}} : lane_en_q;

    // one toggle per bit gives a bit clock at half the bit rate
    always_ff @(posedge link_clk or negedge lrst_n_q) begin
        if (!lrst_n_q) begin
            bitclk_q <= 1'b0;
        end else begin
            bitclk_q <= drv_nx & ~bitclk_q;
        end
    end

    // enables change only on word boundaries so no lane emits a torn word
    always_ff @(posedge link_clk or negedge lrst_n_q) begin
        if (!lrst_n_q) begin
            drv_q         <= 1'b0;
            lane_en_q     <= {NUM_CONV{1'b0}};
            link_active_q <= 1'b0;
        end else if (load) begin
            drv_q         <= drv_nx;
            lane_en_q     <= lane_en_nx;
            link_active_q <= at_link[NUM_CONV];
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NUM_CONV; gi++) begin : g_lane
            aso_lane #(
                .WIDTH (WORD_BITS)
            ) u_lane (
                .clk    (link_clk),
                .rst_n  (lrst_n_q),
                .load   (load),
                .word   (conv_result[gi*WORD_BITS +: WORD_BITS]),
                .enable (lane_en_nx[gi]),
                .ser_q  (lane_data[gi])
            );
        end
    endgenerate

    assign conv_odd      = odd_q;
    assign frame_out     = frame_q;
    assign bitclk_out    = bitclk_q;
    assign serial_drv_en = drv_q;
    assign lane_en       = lane_en_q;

endmodule : aso_top

// ==== bench/aso_top_sva.sv ====
`timescale 1ns/10ps
module aso_sva #(
    parameter int NUM_CONV = 8
) (
    // apb side
    input wire logic                pclk,
    input wire logic                presetn,
    input wire logic                psel,
    input wire logic                penable,
    input wire logic                pready,
    input wire logic                pslverr,
    // power controls
    input wire logic                reference_en,
    input wire logic                core_en,
    input wire logic [NUM_CONV-1:0] pair_power_en,
    // link side
    input wire logic                link_clk,
    input wire logic                conv_odd,
    input wire logic [NUM_CONV-1:0] lane_en,
    input wire logic                frame_out,
    input wire logic                bitclk_out,
    input wire logic                serial_drv_en
);
    // run length of the current frame level, counted only while drivers are on
    logic       frame_prev_q;
    logic [3:0] frame_run_q;

    always_ff @(posedge link_clk or negedge presetn) begin
        if (!presetn) begin
            frame_prev_q <= 1'b0;
            frame_run_q  <= 4'h0;
        end else begin
            frame_prev_q <= frame_out;
            if (!serial_drv_en) begin
                frame_run_q <= 4'h0;
            end else if (frame_out != frame_prev_q) begin
                frame_run_q <= 4'h1;
            end else if (frame_run_q != 4'hF) begin
                frame_run_q <= frame_run_q + 4'h1;
            end
        end
    end

    AST_APB_WAIT: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && !pready |=> pready) else $error("pready late");
    AST_APB_ONE: assert property (@(posedge pclk) disable iff (!presetn)
        pready |=> !pready) else $error("pready held too long");
    AST_SLVERR: assert property (@(posedge pclk) disable iff (!presetn)
        pslverr |-> pready) else $error("pslverr without pready");
    // one cycle of slack, although the pair enables and core_en are set in the same register stage from pwr_d
    AST_PAIR_OFF: assert property (@(posedge pclk) disable iff (!presetn)
        !core_en && !$past(core_en) |-> pair_power_en == '0)
        else $error("pair powered while core off");
    AST_REF_CORE: assert property (@(posedge pclk) disable iff (!presetn)
        !reference_en && !$past(reference_en) |-> !core_en)
        else $error("core on without reference");
    AST_BITCLK: assert property (@(posedge link_clk) disable iff (!presetn)
        serial_drv_en && $past(serial_drv_en) |-> bitclk_out != $past(bitclk_out))
        else $error("bit clock missed a toggle");
    // a first level after the drivers come on may be short, hence the nonzero guard
    AST_FRAME_LEN: assert property (@(posedge link_clk) disable iff (!presetn)
        serial_drv_en && frame_out != frame_prev_q && frame_run_q != 4'h0
        |-> frame_run_q == 4'hC)
        else $error("frame level not twelve bits long");
    AST_FRAME_PARITY: assert property (@(posedge link_clk) disable iff (!presetn)
        serial_drv_en && $past(serial_drv_en) |-> frame_out == !conv_odd)
        else $error("frame level disagrees with word parity");
    AST_DRV_OFF: assert property (@(posedge link_clk) disable iff (!presetn)
        !serial_drv_en && !$past(serial_drv_en)
        |-> !bitclk_out && !frame_out && lane_en == '0)
        else $error("serial outputs active while powered down");
endmodule : aso_sva

bind aso_top aso_sva #(.NUM_CONV(NUM_CONV)) u_aso_sva (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .reference_en(reference_en),
    .core_en(core_en), .pair_power_en(pair_power_en), .link_clk(link_clk),
    .conv_odd(conv_odd), .lane_en(lane_en), .frame_out(frame_out),
    .bitclk_out(bitclk_out), .serial_drv_en(serial_drv_en)
);

// ==== bench/aso_rx_model.sv ====
`timescale 1ns/10ps
module aso_rx_model (
    // link side
    input  wire logic        link_clk,
    input  wire logic [7:0]  lane_data,
    input  wire logic        frame_out,
    // recovered words
    output logic      [95:0] rx_even,
    output logic      [95:0] rx_odd
);
    logic        frame_q = 1'b0;
    logic [3:0]  cnt_q = 4'h0;
    logic [95:0] sh_q;

    // a frame edge marks the first bit of every word
    always_ff @(posedge link_clk) begin
        frame_q <= frame_out;
        cnt_q   <= (frame_out != frame_q) ? 4'h1 : cnt_q + 4'h1;
        for (int i = 0; i < 8; i++) begin
            sh_q[12*i +: 12] <= {sh_q[12*i +: 11], lane_data[i]};
        end
    end

    // twelfth bit closes the word; frame high means the even channel
    always_ff @(posedge link_clk) begin
        if (frame_out == frame_q && cnt_q == 4'hB) begin
            for (int i = 0; i < 8; i++) begin
                if (frame_out) begin
                    rx_even[12*i +: 12] <= {sh_q[12*i +: 11], lane_data[i]};
                end else begin
                    rx_odd[12*i +: 12] <= {sh_q[12*i +: 11], lane_data[i]};
                end
            end
        end
    end
endmodule : aso_rx_model

// ==== bench/tb_top.sv ====
`timescale 1ns/10ps
module tb_top;
    localparam int WAKE_FULL = 120;
    logic        pclk = 1'b0;
    logic        link_clk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        reference_en;
    logic        core_en;
    logic [7:0]  pair_power_en;
    logic [95:0] conv_result;
    logic        conv_odd;
    logic [7:0]  lane_data;
    logic [7:0]  lane_en;
    logic        frame_out;
    logic        bitclk_out;
    logic        serial_drv_en;
    logic [95:0] rx_even;
    logic [95:0] rx_odd;
    logic [31:0] rd;
    logic        er;
    int          n_fail;
    int          tests_run;

    aso_top #(.WAKE_FULL_CYC(WAKE_FULL)) dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .reference_en(reference_en),
        .core_en(core_en), .pair_power_en(pair_power_en), .link_clk(link_clk),
        .conv_result(conv_result), .conv_odd(conv_odd), .lane_data(lane_data),
        .lane_en(lane_en), .frame_out(frame_out), .bitclk_out(bitclk_out),
        .serial_drv_en(serial_drv_en)
    );

    aso_rx_model rx_u (
        .link_clk(link_clk), .lane_data(lane_data), .frame_out(frame_out),
        .rx_even(rx_even), .rx_odd(rx_odd)
    );

    always #10 pclk = ~pclk;

    // offset so that two link edges fall inside the reset pulse
    initial begin
        link_clk = 1'b0;
        #6;
        forever begin
            link_clk = ~link_clk;
            #32;
        end
    end

    function automatic logic [95:0] pats(input logic odd, input logic [7:0] off);
        logic [95:0] v;
        for (int i = 0; i < 8; i++) begin
            v[12*i +: 12] = off[i] ? 12'h000 : (odd ? 12'h5C0 : 12'hA30) + 12'(i);
        end
        return v;
    endfunction : pats

    // next loaded word has the parity opposite to the one now on the wire
    always @(posedge link_clk) begin
        conv_result <= pats(!conv_odd, 8'h00);
    end

    task automatic chk(input logic [95:0] seen, input logic [95:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, rd, er);
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0, rd, er);
        chk(96'(rd & m), 96'(e));
    endtask : rdc

    task automatic idle(input int n);
        repeat (n) @(posedge pclk);
    endtask : idle

    task automatic results;
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : results

    initial begin
        #200000;
        n_fail++;
        results();
    end

    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        n_fail = 0;
        tests_run = 0;
        presetn = 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rdc(aso_pkg::ADDR_CTRL, 32'hFFFFFFFF, 32'h0);
        rdc(aso_pkg::ADDR_PAIR_PD, 32'hFFFFFFFF, 32'h0);
        rdc(aso_pkg::ADDR_STATUS, 32'h7, 32'h7);
        apb(1'b0, 8'h0C, 32'h0, rd, er);
        chk(96'({er, rd}), 96'({1'b1, 32'h0}));
        $display("test registers done");
        idle(400);
        chk(rx_even, pats(1'b0, 8'h00));
        chk(rx_odd, pats(1'b1, 8'h00));
        rdc(aso_pkg::ADDR_STATUS, 32'hF, 32'hF);
        $display("test stream done");
        wr(aso_pkg::ADDR_PAIR_PD, 32'h81);
        rdc(aso_pkg::ADDR_PAIR_PD, 32'hFF, 32'h81);
        chk(96'(pair_power_en), 96'(8'h7E));
        idle(400);
        chk(rx_even, pats(1'b0, 8'h81));
        chk(rx_odd, pats(1'b1, 8'h81));
        wr(aso_pkg::ADDR_PAIR_PD, 32'h0);
        $display("test pair powerdown done");
        wr(aso_pkg::ADDR_CTRL, 32'h4);
        idle(400);
        chk(96'({serial_drv_en, lane_en, core_en}), 96'({1'b0, 8'h00, 1'b1}));
        rdc(aso_pkg::ADDR_STATUS, 32'h8, 32'h0);
        wr(aso_pkg::ADDR_CTRL, 32'h0);
        idle(400);
        chk(rx_odd, pats(1'b1, 8'h00));
        $display("test serial powerdown done");
        wr(aso_pkg::ADDR_CTRL, 32'h1);
        idle(4);
        chk(96'({reference_en, core_en}), 96'(2'b10));
        rdc(aso_pkg::ADDR_STATUS, 32'h7, 32'h2);
        wr(aso_pkg::ADDR_CTRL, 32'h0);
        idle(60);
        rdc(aso_pkg::ADDR_STATUS, 32'h1, 32'h1);
        $display("test standby done");
        wr(aso_pkg::ADDR_CTRL, 32'h3);
        idle(4);
        chk(96'({reference_en, core_en}), 96'(2'b00));
        wr(aso_pkg::ADDR_CTRL, 32'h0);
        idle(60);
        rdc(aso_pkg::ADDR_STATUS, 32'h1, 32'h0);
        idle(100);
        rdc(aso_pkg::ADDR_STATUS, 32'h1, 32'h1);
        $display("test full powerdown done");
        results();
    end
endmodule : tb_top
